/* File: logic/bcd_core.sv */
// Purpose: Fetch, decode and sequencing of branches, bit tests,
//          product, read-modify-write and register/memory classes.
// Assumes: Memory answers a read within the cycle that rd is high.
// Notes:   Control and bit set/clear instructions are not decoded.
// Operation
// - Taken relative branch adds signed offset.
// - Untaken branch continues at next instruction.
// - Offset is signed, from following location.
// - Bit-test span is -128 to +127.
// - Relative mode only for branches, bit-tests and the relative call.
// - Product: high byte index, low accumulator.
// - Modify instructions write back same place.
// - Flag probe reads, sets flags, never writes.
// - Modify accepts inherent, direct, indexed, indexed-8.
// - Register/memory uses six memory addressing modes.
// - Jumps use direct, extended, three indexed modes.
// - Bit-test is opcode, address, offset bytes.
// - Bit-test reaches first 256 addresses directly.
// - Opcode gives bit number and polarity.
// - True bit test adds third byte.
// - Tested bit always copied into carry.
// - Branches test interrupt pin high and low.
// - Branches on half-carry clear and set.
// - Branches on interrupt mask clear and set.
// - One internal cycle per two clocks.
`timescale 1ns/100ps
module bcd_core
  import bcd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Memory request and read data.
  output bcd_bus_s mem_req,
  input wire logic [7:0] mem_rdata,
  // External interrupt pin and mask load from control logic.
  input wire logic int_line,
  input wire logic mask_load,
  input wire logic mask_value,
  // Visible core state.
  output logic [15:0] pc,
  output logic [7:0] acc,
  output logic [7:0] idx,
  output logic [7:0] sp,
  output bcd_flags_s flags,
  // One-cycle event pulses.
  output logic instr_done,
  output logic decode_fault,
  output logic branch_taken
);

  // ----------------------------------------------------------------
  // Decode helpers.
  // ----------------------------------------------------------------

  // Class and mode of an opcode; anything unlisted is refused.
  function automatic bcd_dec_s decode(input logic [7:0] o);
    bcd_dec_s d;
    d.cls = CL_BAD;
    d.mode = M_INH;
    if (o[7:4] == HI_BITBR)
    begin
      d.cls = CL_BITBR;
      d.mode = M_DIR;
    end
    else if (o[7:4] == HI_BR)
    begin
      d.cls = CL_BR;
      d.mode = M_REL;
    end
    else if (o == OP_PRODUCT)
    begin
      d.cls = CL_MUL;
    end
    else if (o == OP_CALL_REL)
    begin
      d.cls = CL_CALL;
      d.mode = M_REL;
    end
    else if (o[7:4] >= HI_RMW_DIR && o[7:4] <= HI_RMW_IX &&
             RMW_LEGAL[o[3:0]])
    begin
      // Only four modes exist for this class.
      d.cls = CL_RMW;
      case (o[7:4])
        HI_RMW_DIR: d.mode = M_DIR;
        HI_RMW_IX1: d.mode = M_IX1;
        HI_RMW_IX: d.mode = M_IX;
        default: d.mode = M_INH;
      endcase
    end
    else if (o[7:4] >= HI_RM_IMM)
    begin
      d.cls = CL_RM;
      case (o[7:4])
        HI_RM_IMM: d.mode = M_IMM;
        HI_RM_DIR: d.mode = M_DIR;
        HI_RM_EXT: d.mode = M_EXT;
        HI_RM_IX2: d.mode = M_IX2;
        HI_RM_IX1: d.mode = M_IX1;
        default: d.mode = M_IX;
      endcase
      // Stores and jumps have no immediate form.
      if (d.mode == M_IMM && (o[3:0] == RM_STA || o[3:0] == RM_STX ||
          o[3:0] == RM_JUMP || o[3:0] == RM_CALL))
      begin
        d.cls = CL_BAD;
      end
    end
    return d;
  endfunction

  // Branch condition, flags and the synchronised pin level.
  function automatic logic cond(input logic [3:0] k,
                                input bcd_flags_s f, input logic pin);
    case (k)
      BC_ALWAYS: cond = 1'b1;
      BC_NEVER: cond = 1'b0;
      BC_HI: cond = !(f.c | f.z);
      BC_LS: cond = f.c | f.z;
      BC_CC: cond = !f.c;
      BC_CS: cond = f.c;
      BC_NE: cond = !f.z;
      BC_EQ: cond = f.z;
      BC_HCC: cond = !f.h;
      BC_HCS: cond = f.h;
      BC_PL: cond = !f.n;
      BC_MI: cond = f.n;
      BC_MC: cond = !f.i;
      BC_MS: cond = f.i;
      BC_IL: cond = !pin;
      default: cond = pin;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic phase; // High in the second clock of an internal cycle.
  logic int_meta; // First synchroniser stage, read by int_sync only.
  logic int_sync; // Pin level safe to use.
  bcd_state_e state;
  bcd_class_e cls;
  bcd_mode_e mode;
  logic [7:0] op; // Current opcode.
  logic [7:0] b1; // First operand byte.
  logic [7:0] b2; // Second operand byte.
  logic [7:0] opnd; // Data operand.
  logic [7:0] wbyte; // Byte to be written back.
  logic [15:0] dest; // Call destination held across the push.
  logic [15:0] ea; // Effective address from held bytes.
  logic [15:0] pc_inc; // Address of the following location.
  logic [15:0] rel_dest; // Relative target from the byte on the bus.
  bcd_dec_s dec; // Decode of the byte on the bus.
  // Next values.
  bcd_state_e next_state;
  bcd_class_e next_cls;
  bcd_mode_e next_mode;
  logic [7:0] next_op, next_b1, next_b2, next_opnd, next_wbyte;
  logic [7:0] next_acc, next_idx, next_sp;
  logic [15:0] next_pc, next_dest;
  bcd_flags_s next_flags;
  logic next_done, next_fault, next_taken;
  bcd_bus_s cur_bus;

  // Offset is sign-extended; one span for every relative form.
  assign pc_inc = pc + PC_STEP;
  assign rel_dest = pc_inc + {{8{mem_rdata[7]}}, mem_rdata};
  assign dec = decode(mem_rdata);

  // Effective address; indexed-8 may cross into page one.
  always_comb
  begin
    case (mode)
      M_EXT: ea = {b1, b2};
      M_IX: ea = {PAGE0, idx};
      M_IX1: ea = {PAGE0, b1} + {PAGE0, idx};
      M_IX2: ea = {b1, b2} + {PAGE0, idx};
      default: ea = {PAGE0, b1};
    endcase
  end

  // Memory request for the present state.
  always_comb
  begin
    cur_bus = '0;
    case (state)
      S_FETCH, S_OPB1, S_OPB2:
      begin
        cur_bus.rd = 1'b1;
        cur_bus.addr = pc;
      end
      S_READ:
      begin
        cur_bus.rd = 1'b1;
        cur_bus.addr = ea;
      end
      S_WRITE:
      begin
        cur_bus.wr = 1'b1;
        cur_bus.addr = ea;
        cur_bus.wdata = wbyte;
      end
      S_PUSHL, S_PUSHH:
      begin
        cur_bus.wr = 1'b1;
        cur_bus.addr = {PAGE0, sp};
        cur_bus.wdata = (state == S_PUSHL) ? pc[7:0] : pc[15:8];
      end
      default: cur_bus = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer next-state logic.
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [8:0] sum;
    logic [7:0] res;
    logic [7:0] r;
    logic [15:0] prod;
    logic bitv;
    sum = '0;
    res = '0;
    r = '0;
    prod = '0;
    bitv = 1'b0;
    next_state = state;
    next_cls = cls;
    next_mode = mode;
    next_op = op;
    next_b1 = b1;
    next_b2 = b2;
    next_opnd = opnd;
    next_wbyte = wbyte;
    next_acc = acc;
    next_idx = idx;
    next_sp = sp;
    next_pc = pc;
    next_dest = dest;
    next_flags = flags;
    next_done = 1'b0;
    next_fault = 1'b0;
    next_taken = 1'b0;
    case (state)
      S_FETCH:
      begin
        next_op = mem_rdata;
        next_cls = dec.cls;
        next_mode = dec.mode;
        next_pc = pc_inc;
        // Inherent operand comes from a register.
        next_opnd = mem_rdata[4] ? idx : acc;
        if (dec.cls == CL_BAD)
        begin
          next_fault = 1'b1;
        end
        else if (dec.mode == M_INH)
        begin
          next_state = S_EXEC;
        end
        else if (dec.mode == M_IX)
        begin
          next_state = (dec.cls == CL_RM && (mem_rdata[3:0] == RM_STA ||
            mem_rdata[3:0] >= RM_JUMP && mem_rdata[3:0] != RM_LDX))
            ? S_EXEC : S_READ;
        end
        else
        begin
          next_state = S_OPB1;
        end
      end
      S_OPB1:
      begin
        next_b1 = mem_rdata;
        next_opnd = mem_rdata;
        next_pc = pc_inc;
        if (cls == CL_BR)
        begin
          // Taken adds offset, otherwise next instruction.
          if (cond(op[3:0], flags, int_sync))
          begin
            next_pc = rel_dest;
            next_taken = 1'b1;
          end
          next_done = 1'b1;
          next_state = S_FETCH;
        end
        else if (cls == CL_CALL)
        begin
          next_dest = rel_dest;
          next_state = S_PUSHL;
        end
        else if (cls == CL_BITBR)
        begin
          next_state = S_READ;
        end
        else if (mode == M_EXT || mode == M_IX2)
        begin
          next_state = S_OPB2;
        end
        else if (mode == M_IMM || (cls == CL_RM && (op[3:0] == RM_STA ||
                 op[3:0] >= RM_JUMP && op[3:0] != RM_LDX)))
        begin
          next_state = S_EXEC;
        end
        else
        begin
          next_state = S_READ;
        end
      end
      S_OPB2:
      begin
        next_b2 = mem_rdata;
        next_pc = pc_inc;
        if (cls == CL_BITBR)
        begin
          // Bit number and polarity sit in the opcode.
          bitv = opnd[op[3:1]];
          next_flags.c = bitv;
          if (bitv == op[0])
          begin
            next_pc = rel_dest;
            next_taken = 1'b1;
          end
          next_done = 1'b1;
          next_state = S_FETCH;
        end
        else
        begin
          next_state = (op[3:0] == RM_STA || op[3:0] >= RM_JUMP &&
            op[3:0] != RM_LDX) ? S_EXEC : S_READ;
        end
      end
      S_READ:
      begin
        next_opnd = mem_rdata;
        next_state = (cls == CL_BITBR) ? S_OPB2 : S_EXEC;
      end
      S_EXEC:
      begin
        next_state = S_FETCH;
        next_done = 1'b1;
        if (cls == CL_MUL)
        begin
          prod = {BYTE0, acc} * {BYTE0, idx};
          next_idx = prod[15:8];
          next_acc = prod[7:0];
          next_flags.h = 1'b0;
          next_flags.c = 1'b0;
        end
        else if (cls == CL_RMW)
        begin
          sum = {1'b0, opnd};
          case (op[3:0])
            RMW_NEG: sum = {opnd != BYTE0, BYTE0 - opnd};
            RMW_COM: sum = {1'b1, ~opnd};
            RMW_LSR: sum = {opnd[0], 1'b0, opnd[7:1]};
            RMW_ROR: sum = {opnd[0], flags.c, opnd[7:1]};
            RMW_ASR: sum = {opnd[0], opnd[7], opnd[7:1]};
            RMW_LSL: sum = {opnd, 1'b0};
            RMW_ROL: sum = {opnd, flags.c};
            RMW_DEC: sum = {flags.c, opnd - SP_STEP};
            RMW_INC: sum = {flags.c, opnd + SP_STEP};
            RMW_CLR: sum = {flags.c, BYTE0};
            default: sum = {flags.c, opnd};
          endcase
          next_flags.c = sum[8];
          next_flags.n = sum[7];
          next_flags.z = (sum[7:0] == BYTE0);
          if (mode == M_INH)
          begin
            // Register form writes the same register back.
            if (op[4])
            begin
              next_idx = sum[7:0];
            end
            else
            begin
              next_acc = sum[7:0];
            end
            if (op[3:0] == RMW_PROBE)
            begin
              next_acc = acc;
              next_idx = idx;
            end
          end
          else if (op[3:0] != RMW_PROBE)
          begin
            next_wbyte = sum[7:0];
            next_done = 1'b0;
            next_state = S_WRITE;
          end
        end
        else
        begin
          // Register/memory class.
          r = (op[3:0] == RM_CPX) ? idx : acc;
          res = opnd;
          case (op[3:0])
            RM_SUB, RM_CMP, RM_SBC, RM_CPX:
            begin
              sum = {1'b0, r} - {1'b0, opnd} -
                {BYTE0, (op[3:0] == RM_SBC) & flags.c};
              next_flags.c = sum[8];
              res = sum[7:0];
              if (op[3:0] == RM_SUB || op[3:0] == RM_SBC)
              begin
                next_acc = res;
              end
            end
            RM_ADD, RM_ADC:
            begin
              sum = {1'b0, r} + {1'b0, opnd} +
                {BYTE0, (op[3:0] == RM_ADC) & flags.c};
              next_flags.c = sum[8];
              next_flags.h = r[4] ^ opnd[4] ^ sum[4];
              res = sum[7:0];
              next_acc = res;
            end
            RM_AND, RM_BIT:
            begin
              res = acc & opnd;
              if (op[3:0] == RM_AND)
              begin
                next_acc = res;
              end
            end
            RM_EOR:
            begin
              res = acc ^ opnd;
              next_acc = res;
            end
            RM_ORA:
            begin
              res = acc | opnd;
              next_acc = res;
            end
            RM_LDA: next_acc = opnd;
            RM_LDX: next_idx = opnd;
            RM_STA, RM_STX:
            begin
              res = (op[3:0] == RM_STA) ? acc : idx;
              next_wbyte = res;
              next_done = 1'b0;
              next_state = S_WRITE;
            end
            RM_JUMP: next_pc = ea;
            default:
            begin
              next_dest = ea;
              next_done = 1'b0;
              next_state = S_PUSHL;
            end
          endcase
          // Jumps leave the flags untouched.
          if (op[3:0] != RM_JUMP && op[3:0] != RM_CALL)
          begin
            next_flags.n = res[7];
            next_flags.z = (res == BYTE0);
          end
        end
      end
      S_WRITE:
      begin
        next_done = 1'b1;
        next_state = S_FETCH;
      end
      S_PUSHL:
      begin
        next_sp = sp - SP_STEP;
        next_state = S_PUSHH;
      end
      S_PUSHH:
      begin
        next_sp = sp - SP_STEP;
        next_pc = dest;
        next_taken = (cls == CL_CALL);
        next_done = 1'b1;
        next_state = S_FETCH;
      end
      default: next_state = S_FETCH;
    endcase
  end

  // ----------------------------------------------------------------
  // Clocked processes.
  // ----------------------------------------------------------------

  // Internal cycle phase: the core registers move every second
  // clock, so memory sees each request for a full clock.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      phase <= 1'b0;
    else
      phase <= !phase;
  end

  // Pin synchroniser.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      int_meta <= 1'b0;
      int_sync <= 1'b0;
    end
    else
    begin
      int_meta <= int_line;
      int_sync <= int_meta;
    end
  end

  // Core registers; a mask load lands on any clock and wins.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= S_FETCH;
      cls <= CL_BAD;
      mode <= M_INH;
      op <= BYTE0;
      b1 <= BYTE0;
      b2 <= BYTE0;
      opnd <= BYTE0;
      wbyte <= BYTE0;
      acc <= BYTE0;
      idx <= BYTE0;
      sp <= SP_RESET;
      pc <= PC_RESET;
      dest <= PC_RESET;
      flags <= FLAGS_RESET;
    end
    else
    begin
      if (phase)
      begin
        state <= next_state;
        cls <= next_cls;
        mode <= next_mode;
        op <= next_op;
        b1 <= next_b1;
        b2 <= next_b2;
        opnd <= next_opnd;
        wbyte <= next_wbyte;
        acc <= next_acc;
        idx <= next_idx;
        sp <= next_sp;
        pc <= next_pc;
        dest <= next_dest;
        flags <= next_flags;
      end
      if (mask_load)
        flags.i <= mask_value;
    end
  end

  // Bus request shown in the second clock; events pulse once.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_req <= '0;
      instr_done <= 1'b0;
      decode_fault <= 1'b0;
      branch_taken <= 1'b0;
    end
    else
    begin
      mem_req <= phase ? '0 : cur_bus;
      instr_done <= phase & next_done;
      decode_fault <= phase & next_fault;
      branch_taken <= phase & next_taken;
    end
  end

endmodule // bcd_core

/* File: logic/bcd_pkg.sv */
// Purpose: Shared types and constants of the branch and class decoder.
// Assumes: Opcode layout below is local to this core.
// Notes:   One internal cycle spans two ref_clk cycles.
package bcd_pkg;
  // ----------------------------------------------------------------
  // Sequencer states, instruction classes and addressing modes.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_FETCH = 4'h0, S_OPB1 = 4'h1, S_OPB2 = 4'h2, S_READ = 4'h3,
    S_EXEC = 4'h4, S_WRITE = 4'h5, S_PUSHL = 4'h6, S_PUSHH = 4'h7
  } bcd_state_e;
  typedef enum logic [2:0] {
    CL_BAD = 3'h0, CL_BITBR = 3'h1, CL_BR = 3'h2, CL_MUL = 3'h3,
    CL_RMW = 3'h4, CL_RM = 3'h5, CL_CALL = 3'h6
  } bcd_class_e;
  typedef enum logic [2:0] {
    M_INH = 3'h0, M_IMM = 3'h1, M_DIR = 3'h2, M_EXT = 3'h3,
    M_IX = 3'h4, M_IX1 = 3'h5, M_IX2 = 3'h6, M_REL = 3'h7
  } bcd_mode_e;
  // Flag bits of the flags_register, and a memory request.
  typedef struct packed {logic h; logic i; logic n; logic z; logic c;}
    bcd_flags_s;
  typedef struct packed {logic rd; logic wr; logic [15:0] addr;
    logic [7:0] wdata;} bcd_bus_s;
  typedef struct packed {bcd_class_e cls; bcd_mode_e mode;} bcd_dec_s;
  // ----------------------------------------------------------------
  // Opcode fields (upper nibble selects class and mode).
  // ----------------------------------------------------------------
  localparam logic [3:0] HI_BITBR = 4'h0, HI_BR = 4'h2;
  localparam logic [3:0] HI_RMW_DIR = 4'h3, HI_RMW_A = 4'h4;
  localparam logic [3:0] HI_RMW_X = 4'h5, HI_RMW_IX1 = 4'h6;
  localparam logic [3:0] HI_RMW_IX = 4'h7, HI_RM_IMM = 4'hA;
  localparam logic [3:0] HI_RM_DIR = 4'hB, HI_RM_EXT = 4'hC;
  localparam logic [3:0] HI_RM_IX2 = 4'hD, HI_RM_IX1 = 4'hE;
  localparam logic [3:0] HI_RM_IX = 4'hF;
  localparam logic [7:0] OP_PRODUCT = 8'h42, OP_CALL_REL = 8'hAD;
  // Legal read-modify-write operations, one bit per low nibble.
  localparam logic [15:0] RMW_LEGAL = 16'hB7D9;
  localparam logic [3:0] RMW_NEG = 4'h0, RMW_COM = 4'h3, RMW_LSR = 4'h4;
  localparam logic [3:0] RMW_ROR = 4'h6, RMW_ASR = 4'h7, RMW_LSL = 4'h8;
  localparam logic [3:0] RMW_ROL = 4'h9, RMW_DEC = 4'hA, RMW_INC = 4'hC;
  localparam logic [3:0] RMW_PROBE = 4'hD, RMW_CLR = 4'hF;
  localparam logic [3:0] RM_SUB = 4'h0, RM_CMP = 4'h1, RM_SBC = 4'h2;
  localparam logic [3:0] RM_CPX = 4'h3, RM_AND = 4'h4, RM_BIT = 4'h5;
  localparam logic [3:0] RM_LDA = 4'h6, RM_STA = 4'h7, RM_EOR = 4'h8;
  localparam logic [3:0] RM_ADC = 4'h9, RM_ORA = 4'hA, RM_ADD = 4'hB;
  localparam logic [3:0] RM_JUMP = 4'hC, RM_CALL = 4'hD, RM_LDX = 4'hE;
  localparam logic [3:0] RM_STX = 4'hF;
  // Branch condition codes in the low nibble of a branch opcode.
  localparam logic [3:0] BC_ALWAYS = 4'h0, BC_NEVER = 4'h1;
  localparam logic [3:0] BC_HI = 4'h2, BC_LS = 4'h3, BC_CC = 4'h4;
  localparam logic [3:0] BC_CS = 4'h5, BC_NE = 4'h6, BC_EQ = 4'h7;
  localparam logic [3:0] BC_HCC = 4'h8, BC_HCS = 4'h9, BC_PL = 4'hA;
  localparam logic [3:0] BC_MI = 4'hB, BC_MC = 4'hC, BC_MS = 4'hD;
  localparam logic [3:0] BC_IL = 4'hE, BC_IH = 4'hF;
  // Reset values and arithmetic steps.
  localparam logic [15:0] PC_RESET = 16'h0000, PC_STEP = 16'h0001;
  localparam logic [7:0] SP_RESET = 8'hFF, SP_STEP = 8'h01;
  localparam logic [7:0] PAGE0 = 8'h00, BYTE0 = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h08;
endpackage

/* File: test/bcd_chk.sv */
// Purpose: Timing checks on the decoder's memory bus and event pulses.
// Assumes: Sees only the ports of the core.
// Notes:   One domain, so clocking and disable are declared once.
`timescale 1ns/100ps
module bcd_chk
  import bcd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Bus and flags.
  input bcd_bus_s mem_req,
  input bcd_flags_s flags,
  // Mask load and event pulses.
  input wire logic mask_load,
  input wire logic mask_value,
  input wire logic instr_done,
  input wire logic decode_fault,
  input wire logic branch_taken
);
  // ------------------------------------------------------------
  // Clocking and building blocks.
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // An idle bus cycle, and the all-zero request it must show.
  sequence s_gap;
    !(mem_req.rd || mem_req.wr);
  endsequence
  sequence s_zero;
    mem_req.addr == 16'h0000 && mem_req.wdata == 8'h00;
  endsequence
  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  chk_access_gap: assert property ((mem_req.rd || mem_req.wr) |=> s_gap)
    else $error("bus access held past one cycle");
  chk_idle_zero: assert property (s_gap |-> s_zero)
    else $error("idle bus carries address or data");
  chk_no_rdwr: assert property (!(mem_req.rd && mem_req.wr))
    else $error("read and write in one cycle");
  chk_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done pulse too long");
  chk_fault_pulse: assert property (decode_fault |=> !decode_fault)
    else $error("fault pulse too long");
  chk_taken_done: assert property (branch_taken |-> instr_done)
    else $error("taken without completion");
  chk_taken_cause: assert property (
    branch_taken |-> $past(mem_req.rd || mem_req.wr))
    else $error("taken without a prior access");
  chk_mask_load: assert property (
    mask_load |=> flags.i == $past(mask_value))
    else $error("mask load not applied");
endmodule // bcd_chk

bind bcd_core bcd_chk chk (.ref_clk(ref_clk), .reset(reset),
  .mem_req(mem_req), .flags(flags), .mask_load(mask_load),
  .mask_value(mask_value), .instr_done(instr_done),
  .decode_fault(decode_fault), .branch_taken(branch_taken));

/* File: test/bcd_mem.sv */
// Purpose: Program and data memory beside the core.
// Assumes: Reads answer within the cycle that rd is high.
// Notes:   An idle bus shows the inverse of the last byte read.
`timescale 1ns/100ps
module bcd_mem
  import bcd_pkg::*;
(
  // Clock and request.
  input wire logic ref_clk,
  input bcd_bus_s mem_req,
  // Read data.
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:65535]; // Whole address space.
  logic [7:0] last = 8'h00; // Last byte handed out.
  // Unused space holds a refused opcode so a runaway core stays harmless.
  initial for (int i = 0; i < 65536; i++) ram[i] = 8'h9D;
  // Zero-latency read; an idle bus must never look like valid data.
  assign mem_rdata = mem_req.rd ? ram[mem_req.addr] : ~last;
  // Writes land at the edge that ends the write cycle.
  always @(posedge ref_clk)
  begin
    if (mem_req.wr)
      ram[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd)
      last <= ram[mem_req.addr];
  end
endmodule // bcd_mem

/* File: test/tb.sv */
// Purpose: Self-checking bench for the branch and class decoder.
// Assumes: Memory model answers every read at once.
// Notes:   Each test reboots the core and runs from address 0000.
`timescale 1ns/100ps
module tb;
  import bcd_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic int_line = 1'b0;
  logic mask_load = 1'b0;
  logic mask_value = 1'b0;
  bcd_bus_s mem_req;
  logic [7:0] mem_rdata;
  logic [15:0] pc;
  logic [7:0] acc;
  logic [7:0] idx;
  logic [7:0] sp;
  bcd_flags_s flags;
  logic instr_done;
  logic decode_fault;
  logic branch_taken;
  logic seen_taken;
  logic seen_fault;
  int n_wr;
  int n_errors = 0;
  int num_checks = 0;
  bcd_core uut (.ref_clk(ref_clk), .reset(reset), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .int_line(int_line), .mask_load(mask_load),
    .mask_value(mask_value), .pc(pc), .acc(acc), .idx(idx), .sp(sp),
    .flags(flags), .instr_done(instr_done), .decode_fault(decode_fault),
    .branch_taken(branch_taken));
  bcd_mem mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  initial forever #5 ref_clk = ~ref_clk;
  // Compare and count; an unknown matches only the same unknown.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Short reset; optionally clears the mask on the first edge after.
  task automatic boot(input logic clr_mask);
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    reset = 1'b0;
    mask_load = clr_mask;
    @(negedge ref_clk);
    mask_load = 1'b0;
  endtask
  // Run one instruction, bounded, counting writes on the way.
  task automatic step();
    int n;
    n = 0;
    n_wr = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (mem_req.wr === 1'b1)
        n_wr++;
    end
    while (instr_done !== 1'b1 && decode_fault !== 1'b1 && n < 60);
    check(32'(n >= 60), 32'h0);
    seen_taken = branch_taken;
    seen_fault = decode_fault;
  endtask
  // Every branch code, with mask set and pin low, then the four mask and pin codes with the reverse.
  task automatic t_branch();
    logic [7:0] off;
    logic [3:0] code;
    logic tk;
    for (int k = 0; k < 20; k++)
    begin
      code = (k < 16) ? 4'(k) : 4'(k - 4);
      tk = (k < 16) ? 1'(16'h6555 >> code) : 1'(16'h9000 >> code);
      off = k[0] ? 8'h80 : 8'h7F;
      int_line = (k >= 16);
      mem.ram[0] = {4'h2, code};
      mem.ram[1] = off;
      boot(k >= 16);
      step();
      check(pc, 16'h0002 + (tk ? {{8{off[7]}}, off} : 16'h0000));
      check(seen_taken, tk);
    end
    $display("branch test done");
  endtask
  // Every bit number and polarity against pattern A5 at 00FF.
  task automatic t_bits();
    logic tk;
    logic [7:0] pat = 8'hA5;
    mem.ram[1] = 8'hFF;
    mem.ram[2] = 8'h85;
    mem.ram[16'h00FF] = 8'hA5;
    for (int k = 0; k < 16; k++)
    begin
      tk = (pat[k[3:1]] == k[0]);
      mem.ram[0] = {4'h0, 4'(k)};
      boot(1'b0);
      step();
      check(pc, 16'(16'h0003 + (tk ? 16'hFF85 : 16'h0000)));
      check(flags.c, pat[k[3:1]]);
      check(seen_taken, tk);
    end
    $display("bit test done");
  endtask
  // Product of FF and FD is FC03.
  task automatic t_product();
    mem.ram[0] = 8'hA6;
    mem.ram[1] = 8'hFF;
    mem.ram[2] = 8'hAE;
    mem.ram[3] = 8'hFD;
    mem.ram[4] = 8'h42;
    boot(1'b0);
    repeat (3) step();
    check({idx, acc}, 16'hFC03);
    $display("product test done");
  endtask
  // Modify, probe, four refused forms, an extended jump, a relative call.
  task automatic t_classes();
    logic [7:0] prog [0:10] = '{8'h3C, 8'h40, 8'h3D, 8'h41, 8'h31,
      8'hA7, 8'hAC, 8'h80, 8'hCC, 8'h12, 8'h34};
    for (int i = 0; i < 11; i++)
      mem.ram[i] = prog[i];
    mem.ram[16'h0040] = 8'hFF;
    mem.ram[16'h0041] = 8'h80;
    mem.ram[16'h1234] = 8'hAD;
    mem.ram[16'h1235] = 8'h10;
    boot(1'b0);
    step();
    check({mem.ram[16'h0040], 8'(n_wr)}, 16'h0001);
    step();
    check({flags.n, 8'(n_wr)}, 9'h100);
    for (int k = 5; k < 9; k++)
    begin
      step();
      check({seen_fault, pc}, {1'b1, 16'(k)});
    end
    step();
    check(pc, 16'h1234);
    step();
    check({sp, mem.ram[16'h00FF], mem.ram[16'h00FE]}, 24'hFD3612);
    check({seen_taken, pc}, 17'h11246);
    $display("class test done");
  endtask
  // Counts, verdict and end of run.
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    t_branch();
    t_bits();
    t_product();
    t_classes();
    stop_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule // tb
